// [include/asd_pkg.sv]
// package of constants and types for the analog scaling datapath
// Notes on behaviour
// - 0-10 V and 0-20 mA map to 0..1000
// - 4-20 mA maps to 200..1000
// - standard: standardized times gain, plus offset
// - all arithmetic is whole-number integer
// - physical output takes only 0..1000
// - output voltage held within 0..10 V
// - restricted variant rejects negative gain writes
// - legacy: offset added first, percent gain after
package asd_pkg;
  // ----------------------------------------------------------------
  // widths and ranges
  // ----------------------------------------------------------------
  localparam int ADC_W = 12;
  localparam int SCL_W = 24;
  localparam logic [SCL_W-1:0] NORM_SPAN = 24'h0003E8;
  localparam logic [SCL_W-1:0] ROUND_HALF = 24'h000800;
  localparam logic [10:0] NORM_MAX = 11'h3E8;
  localparam logic [10:0] NORM_LIVE_ZERO = 11'h0C8;
  localparam logic signed [31:0] AOUT_MAX = 32'sh000003E8;
  localparam logic signed [31:0] SCALE_DIV = 32'sh00000064;
  localparam logic [3:0] MV_PER_STEP = 4'hA;
  // ----------------------------------------------------------------
  // register map (byte addresses) and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GAIN = 8'h04;
  localparam logic [7:0] ADDR_OFFSET = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_NORM = 8'h10;
  localparam logic [7:0] ADDR_ANALOG = 8'h14;
  localparam logic [7:0] ADDR_AOUT = 8'h18;
  localparam logic [1:0] SENS_0_10V = 2'h0;
  localparam logic [1:0] SENS_0_20MA = 2'h1;
  localparam logic [1:0] SENS_4_20MA = 2'h2;
  localparam logic [1:0] SENS_NONE = 2'h3;
  localparam logic [1:0] VAR_STANDARD = 2'h0;
  localparam logic [1:0] VAR_RESTRICT = 2'h1;
  localparam logic [1:0] VAR_LEGACY = 2'h2;
  localparam logic [15:0] GAIN_RESET = 16'h0064;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] variant;
    logic [1:0] sensor;
  } asd_ctrl_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_full;
    logic w_full;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } asd_bus_type;

  typedef struct packed {
    asd_bus_type bus;
    asd_ctrl_type ctrl;
    logic signed [15:0] gain;
    logic signed [15:0] offset;
    logic gain_rejected;
    logic [ADC_W-1:0] sync1;
    logic [ADC_W-1:0] sync2;
    logic [10:0] norm;
    logic signed [31:0] analog;
    logic [10:0] aout;
    logic [13:0] aout_mv;
  } asd_state_type;
endpackage

// [src/asd_top.sv]
// analog scaling datapath with an AXI4-Lite register slave
//
// Implementation choices: register access over AXI4-Lite and the address map.
module asd_top
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // converter reading, asynchronous to core_clk
  input wire logic [asd_pkg::ADC_W-1:0] adc_reading,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // results
  output logic [10:0] norm_value,
  output logic signed [31:0] analog_value,
  output logic [10:0] aout_level,
  output logic [13:0] aout_mv
);
  asd_pkg::asd_state_type state;
  asd_pkg::asd_state_type next_state;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-lane merge, used by the control, gain and offset registers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // datapath and register file
  // ----------------------------------------------------------------
  logic [asd_pkg::SCL_W-1:0] scaled;
  logic [10:0] std_val;
  logic signed [31:0] s_std;
  logic signed [31:0] s_gain;
  logic signed [31:0] s_off;
  logic signed [31:0] acc;
  logic signed [31:0] clip;
  logic [31:0] wr_gain;
  logic [31:0] wr_ctrl;
  logic [31:0] wr_off;
  logic do_write;
  logic do_read;
  logic [31:0] rd_data;
  logic rd_hit;
  logic wr_hit;

  always_comb
  begin
    next_state = state;
    // reading passes two flops before the scaler sees it
    next_state.sync1 = adc_reading;
    next_state.sync2 = state.sync1;

    // round to nearest: full-scale count lands on 1000
    scaled = ((asd_pkg::SCL_W)'(state.sync2) * asd_pkg::NORM_SPAN
      + asd_pkg::ROUND_HALF) >> asd_pkg::ADC_W;
    std_val = (scaled > 24'(asd_pkg::NORM_MAX)) ? asd_pkg::NORM_MAX
      : scaled[10:0];
    unique case (state.ctrl.sensor)
      asd_pkg::SENS_4_20MA:
        // live zero: anything below 4 mA reads as the floor
        if (std_val < asd_pkg::NORM_LIVE_ZERO)
          std_val = asd_pkg::NORM_LIVE_ZERO;
      asd_pkg::SENS_NONE:
        std_val = 11'h000;
      default:
        std_val = std_val;
    endcase
    next_state.norm = std_val;

    // integer arithmetic only; gain is in hundredths, hence /100
    s_std = 32'(signed'({1'b0, state.norm}));
    s_gain = 32'(state.gain);
    s_off = 32'(state.offset);
    if (state.ctrl.variant == asd_pkg::VAR_LEGACY)
      acc = ((s_std + s_off) * s_gain) / asd_pkg::SCALE_DIV;
    else
      acc = (s_std * s_gain) / asd_pkg::SCALE_DIV + s_off;
    next_state.analog = acc;

    // physical output saturates rather than wraps
    if (state.analog < 0)
      clip = 32'sh0;
    else if (state.analog > asd_pkg::AOUT_MAX)
      clip = asd_pkg::AOUT_MAX;
    else
      clip = state.analog;
    next_state.aout = clip[10:0];
    // 10 mV per step keeps the drive within 0..10 V
    next_state.aout_mv = 14'(state.aout * asd_pkg::MV_PER_STEP);

    // write address and data are taken in either order
    if (s_axi_awvalid && state.bus.awready)
    begin
      next_state.bus.aw_full = 1'b1;
      next_state.bus.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state.bus.wready)
    begin
      next_state.bus.w_full = 1'b1;
      next_state.bus.wdata = s_axi_wdata;
      next_state.bus.wstrb = s_axi_wstrb;
    end
    if (state.bus.bvalid && s_axi_bready)
      next_state.bus.bvalid = 1'b0;

    do_write = state.bus.aw_full && state.bus.w_full && !state.bus.bvalid;
    wr_ctrl = merge({28'h0, state.ctrl}, state.bus.wdata, state.bus.wstrb);
    wr_gain = merge(32'(state.gain), state.bus.wdata, state.bus.wstrb);
    wr_off = merge(32'(state.offset), state.bus.wdata, state.bus.wstrb);
    wr_hit = 1'b1;
    if (do_write)
    begin
      next_state.bus.aw_full = 1'b0;
      next_state.bus.w_full = 1'b0;
      next_state.bus.bvalid = 1'b1;
      unique case (state.bus.awaddr)
        asd_pkg::ADDR_CTRL:
          next_state.ctrl = wr_ctrl[3:0];
        asd_pkg::ADDR_GAIN:
          // restricted variant refuses a negative gain and flags it
          if (state.ctrl.variant == asd_pkg::VAR_RESTRICT && wr_gain[15])
            next_state.gain_rejected = 1'b1;
          else
            next_state.gain = wr_gain[15:0];
        asd_pkg::ADDR_OFFSET:
          next_state.offset = wr_off[15:0];
        asd_pkg::ADDR_STATUS:
          // write one clears; a reject is a gain write, so the two never meet in one cycle
          if (state.bus.wstrb[0] && state.bus.wdata[0])
            next_state.gain_rejected = 1'b0;
        asd_pkg::ADDR_NORM, asd_pkg::ADDR_ANALOG, asd_pkg::ADDR_AOUT:
          wr_hit = 1'b1; // read-only, write ignored
        default:
          wr_hit = 1'b0;
      endcase
      next_state.bus.bresp = wr_hit ? asd_pkg::RESP_OKAY
        : asd_pkg::RESP_SLVERR;
    end

    // read: one outstanding, answered the cycle after the address
    if (state.bus.rvalid && s_axi_rready)
      next_state.bus.rvalid = 1'b0;
    do_read = s_axi_arvalid && state.bus.arready;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      asd_pkg::ADDR_CTRL: rd_data = {28'h0, state.ctrl};
      asd_pkg::ADDR_GAIN: rd_data = 32'(state.gain);
      asd_pkg::ADDR_OFFSET: rd_data = 32'(state.offset);
      asd_pkg::ADDR_STATUS: rd_data = {31'h0, state.gain_rejected};
      asd_pkg::ADDR_NORM: rd_data = {21'h0, state.norm};
      asd_pkg::ADDR_ANALOG: rd_data = state.analog;
      asd_pkg::ADDR_AOUT: rd_data = {21'h0, state.aout};
      default:
      begin
        rd_data = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
    if (do_read)
    begin
      next_state.bus.rvalid = 1'b1;
      next_state.bus.rdata = rd_data;
      next_state.bus.rresp = rd_hit ? asd_pkg::RESP_OKAY
        : asd_pkg::RESP_SLVERR;
    end

    // readies are registered, so each drops while its slot is busy
    next_state.bus.awready = !next_state.bus.aw_full
      && !next_state.bus.bvalid;
    next_state.bus.wready = !next_state.bus.w_full
      && !next_state.bus.bvalid;
    next_state.bus.arready = !next_state.bus.rvalid;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // clock enable low freezes everything, bus handshakes included
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= '0;
      state.gain <= asd_pkg::GAIN_RESET;
    end
    else if (ce)
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign s_axi_awready = state.bus.awready;
  assign s_axi_wready = state.bus.wready;
  assign s_axi_bvalid = state.bus.bvalid;
  assign s_axi_bresp = state.bus.bresp;
  assign s_axi_arready = state.bus.arready;
  assign s_axi_rvalid = state.bus.rvalid;
  assign s_axi_rdata = state.bus.rdata;
  assign s_axi_rresp = state.bus.rresp;
  assign norm_value = state.norm;
  assign analog_value = state.analog;
  assign aout_level = state.aout;
  assign aout_mv = state.aout_mv;
endmodule

// [tb/asd_top_chk_sva.sv]
// assertion checker for the scaling datapath ports
module asd_top_chk
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // results
  input wire logic [10:0] norm_value,
  input wire logic signed [31:0] analog_value,
  input wire logic [10:0] aout_level,
  input wire logic [13:0] aout_mv
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // the bench offers both write halves together, so both go at one edge
  sequence seq_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence seq_b_rises;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  AST_NORM_RANGE: assert property (norm_value <= 11'h3E8)
    else $error("standardized value above span");
  AST_AOUT_LOW: assert property ($past(analog_value) < 32'sh0 |->
    aout_level == 11'h0) else $error("negative value not clamped");
  AST_AOUT_HIGH: assert property ($past(analog_value) > 32'sh3E8 |->
    aout_level == 11'h3E8) else $error("large value not clamped");
  AST_AOUT_PASS: assert property (!$past(analog_value[31]) &&
    $past(analog_value) <= 32'sh3E8 |-> aout_level == $past(analog_value[10:0]))
    else $error("in-range value altered");
  AST_MV: assert property (aout_mv == $past(aout_level) * 14'hA)
    else $error("output voltage code wrong");
  AST_BRESP: assert property (seq_wr_taken |=> seq_b_rises)
    else $error("write response late");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("response dropped");
  AST_RVALID: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read data late");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule

bind asd_top asd_top_chk i_asd_top_chk
(
  .core_clk(core_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .norm_value(norm_value),
  .analog_value(analog_value), .aout_level(aout_level), .aout_mv(aout_mv)
);

// [tb/asd_adc_model.sv]
// converter model that feeds the raw reading
module asd_adc_model
(
  // wanted count and conversion speed
  input wire logic [11:0] level,
  input wire logic slow,
  // raw reading
  output logic [11:0] adc_reading
);
  timeunit 1ns;
  timeprecision 100ps;
  initial adc_reading = 12'h000;
  // mid-conversion the bits are garbage, shown as the inverse
  always @(level)
  begin
    adc_reading = ~level;
    #(slow ? 27 : 3);
    adc_reading = level;
  end
endmodule

// [tb/tb_top.sv]
// register-level testbench for the scaling datapath
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [11:0] level = 12'h000;
  logic [11:0] adc_reading;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic awready, wready, bvalid, arready, rvalid;
  logic [10:0] norm_value, aout_level;
  logic signed [31:0] analog_value;
  logic [13:0] aout_mv;
  logic [31:0] rd_v;
  logic [1:0] rs;
  int n_errors = 0;
  int check_count = 0;

  always #5 core_clk = ~core_clk;

  asd_adc_model i_asd_adc_model
  (
    .level(level), .slow(level[0]), .adc_reading(adc_reading)
  );
  asd_top i_asd_top
  (
    .core_clk(core_clk), .rst(rst), .ce(ce), .adc_reading(adc_reading),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .norm_value(norm_value),
    .analog_value(analog_value), .aout_level(aout_level), .aout_mv(aout_mv)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ------------------------------------------------------------
  // bus tasks; a wait of 64 edges without an answer ends the run
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      // ready trails the answer by one edge, so the slave must hold it
      if (bvalid) bready <= 1'b1;
    end
    bready <= 1'b0;
    r = bresp;
    if (n == 64)
    begin
      n_errors++;
      test_done();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      // ready trails the answer by one edge, so the slave must hold it
      if (rvalid) rready <= 1'b1;
    end
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (n == 64)
    begin
      n_errors++;
      test_done();
    end
  endtask

  // configure, apply a raw count, let the pipeline settle, compare all
  task automatic run_case(input logic [3:0] ctl, input logic [11:0] raw,
    input logic [31:0] g, input logic [31:0] off, input logic [10:0] en,
    input logic signed [31:0] ea);
    logic [10:0] ao;
    ao = ea < 0 ? 11'h0 : ea > 32'sh3E8 ? 11'h3E8 : ea[10:0];
    wr(8'h00, {28'h0, ctl}, rs);
    wr(8'h04, g, rs);
    wr(8'h08, off, rs);
    level <= raw;
    repeat (12) @(posedge core_clk);
    check(norm_value, en);
    check(analog_value, ea);
    check(aout_level, ao);
    check(aout_mv, ao * 14'hA);
    rd(8'h14, rd_v, rs);
    check(rd_v, ea);
  endtask

  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h04, rd_v, rs);
    check(rd_v, 32'h64);
    run_case(4'h0, 12'h000, 32'sh64, 32'sh0, 11'h0, 32'sh0);
    run_case(4'h0, 12'hFFF, 32'sh64, 32'sh0, 11'h3E8, 32'sh3E8);
    run_case(4'h1, 12'h800, 32'sh64, 32'sh0, 11'h1F4, 32'sh1F4);
    run_case(4'h2, 12'h000, 32'sh64, 32'sh0, 11'h0C8, 32'shC8);
    run_case(4'h3, 12'hFFF, 32'sh64, 32'sh0, 11'h0, 32'sh0);
    run_case(4'h0, 12'hFFF, 32'sh0, 32'sh0, 11'h3E8, 32'sh0);
    run_case(4'h0, 12'h800, 32'sh0F, -32'sh32, 11'h1F4, 32'sh19);
    run_case(4'h0, 12'hFFF, 32'sh3E8, 32'sh2710, 11'h3E8, 32'sh4E20);
    run_case(4'h0, 12'hFFF, -32'sh3E8, -32'sh2710, 11'h3E8, -32'sh4E20);
    run_case(4'h8, 12'hFFF, 32'sh96, 32'sh3E7, 11'h3E8, 32'shBB6);
    run_case(4'hA, 12'h000, 32'sh96, -32'sh3E7, 11'h0C8, -32'sh4AE);
    run_case(4'h4, 12'h800, 32'sh0F, -32'sh32, 11'h1F4, 32'sh19);
    wr(8'h04, 32'hFFFFFFFF, rs);
    check({30'h0, rs}, 32'h0);
    rd(8'h04, rd_v, rs);
    check(rd_v, 32'h0F);
    rd(8'h0C, rd_v, rs);
    check(rd_v, 32'h1);
    wr(8'h0C, 32'h1, rs);
    rd(8'h0C, rd_v, rs);
    check(rd_v, 32'h0);
    wr(8'h1C, 32'h5, rs);
    check({30'h0, rs}, 32'h2);
    rd(8'h1C, rd_v, rs);
    check({30'h0, rs}, 32'h2);
    check(rd_v, 32'h0);
    wr(8'h10, 32'h0, rs);
    check({30'h0, rs}, 32'h0);
    rd(8'h10, rd_v, rs);
    check({30'h0, rs}, 32'h0);
    check(rd_v, 32'h1F4);
    // enable low must freeze the pipeline; the new count lands after
    ce <= 1'b0;
    level <= 12'h000;
    repeat (12) @(posedge core_clk);
    check({21'h0, norm_value}, 32'h1F4);
    ce <= 1'b1;
    repeat (12) @(posedge core_clk);
    check({21'h0, norm_value}, 32'h0);
    test_done();
  end
endmodule
